/* operator_model.sv */
// Behavioural operator pressing the two buttons
`timescale 1ns/10ps
`default_nettype none
module operator_model (
    // Clock
    input wire logic core_clk_i,
    // Button pins, low while pressed
    output logic on_btn_n_o,
    output logic off_btn_n_o
);
    initial begin
        on_btn_n_o = 1'b1;
        off_btn_n_o = 1'b1;
    end
    // Pins move on the falling edge only, well clear of sampling
    task automatic push(input logic on_p, input logic off_p);
        @(negedge core_clk_i);
        on_btn_n_o = ~on_p;
        off_btn_n_o = ~off_p;
    endtask
    task automatic release_all();
        @(negedge core_clk_i);
        on_btn_n_o = 1'b1;
        off_btn_n_o = 1'b1;
    endtask
endmodule // operator_model
`default_nettype wire

/* pin_tick.v */
// Pin synchronisers and the 1 ms tick divider
`timescale 1ns/10ps
`default_nettype none
`include "teach_map.vh"

module pin_tick #(
    parameter [15:0] TICK_DIV = `TICK_CYCLES
) (
    // Clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    // Raw pins
    input wire on_btn_n_i,
    input wire off_btn_n_i,
    input wire supply_ok_i,
    // Synchronised levels and tick
    output reg on_press_o,
    output reg off_press_o,
    output reg supply_ok_o,
    output reg tick_o
);

    reg [2:0] meta_ff;
    reg [15:0] div_ff;

    // ****************************************
    // Two-stage synchronisers
    // ****************************************
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_ff <= 3'h7;
            on_press_o <= 1'b0;
            off_press_o <= 1'b0;
            supply_ok_o <= 1'b0;
        end else begin
            meta_ff <= {supply_ok_i, off_btn_n_i, on_btn_n_i};
            on_press_o <= ~meta_ff[0];
            off_press_o <= ~meta_ff[1];
            supply_ok_o <= meta_ff[2];
        end
    end

    // ****************************************
    // Tick divider
    // ****************************************
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_ff <= 16'h0000;
            tick_o <= 1'b0;
        end else if (div_ff == TICK_DIV - 16'h0001) begin
            div_ff <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            div_ff <= div_ff + 16'h0001;
            tick_o <= 1'b0;
        end
    end

endmodule // pin_tick
`default_nettype wire

/* teach_ctrl.v */
// Pushbutton teach-in, lock and LED indication for a presence sensor
`timescale 1ns/10ps
`default_nettype none
`include "teach_map.vh"

module teach_ctrl #(
    parameter [15:0] TICK_DIV = `TICK_CYCLES
) (
    // Clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    // Pins
    input wire on_btn_n_i,
    input wire off_btn_n_i,
    input wire supply_ok_i,
    // Measurement from the optical front end
    input wire [`MEAS_W-1:0] meas_i,
    // Indicators and output
    output reg green_led_o,
    output reg yellow_led_o,
    output reg switch_out_o,
    output reg lock_o,
    output reg teach_busy_o
);

    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_HOLD1 = 4'h1;
    localparam [3:0] ST_WAIT2 = 4'h2;
    localparam [3:0] ST_HOLD2 = 4'h3;
    localparam [3:0] ST_FAIL = 4'h4;
    localparam [3:0] ST_BOTH = 4'h5;
    localparam [3:0] ST_ACK = 4'h6;
    localparam [3:0] ST_REARM = 4'h7;

    localparam [13:0] HOLD_TEACH_T = `HOLD_TEACH_MS;
    localparam [13:0] HOLD_LOCK_T = `HOLD_LOCK_MS;
    localparam [19:0] TEACH_MAX_T = `TEACH_MAX_MS;
    localparam [7:0] FAIL_HALF_T = `FAIL_HALF_MS;
    localparam [7:0] TEACH_HALF_T = `TEACH_HALF_MS;
    localparam [11:0] FAIL_SHOW_T = `FAIL_SHOW_MS;
    localparam [11:0] ACK_T = `ACK_MS;

    wire on_press;
    wire off_press;
    wire supply_ok;
    wire tick;

    reg [3:0] state_ff, nxt_state;
    reg [13:0] hold_cnt_ff, nxt_hold_cnt;
    reg [19:0] teach_cnt_ff, nxt_teach_cnt;
    reg [11:0] show_cnt_ff, nxt_show_cnt;
    reg [7:0] flash_cnt_ff, nxt_flash_cnt;
    reg flash_ff, nxt_flash;
    reg first_off_ff, nxt_first_off;
    reg [`MEAS_W-1:0] ref1_ff, nxt_ref1;
    reg [`MEAS_W-1:0] thr_ff, nxt_thr;
    reg inv_ff, nxt_inv;
    reg lock_ff, nxt_lock;

    reg [`MEAS_W-1:0] hi, lo, diff, gap;
    reg [7:0] half_t;
    reg detect, stable, out_lvl, flashing;
    reg first_btn, second_btn;

    pin_tick #(
        .TICK_DIV(TICK_DIV)
    ) u_pin_tick (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .on_btn_n_i(on_btn_n_i),
        .off_btn_n_i(off_btn_n_i),
        .supply_ok_i(supply_ok_i),
        .on_press_o(on_press),
        .off_press_o(off_press),
        .supply_ok_o(supply_ok),
        .tick_o(tick)
    );

    // ****************************************
    // Detection, stability and reference math
    // ****************************************
    always @* begin
        detect = (meas_i >= thr_ff);
        gap = detect ? (meas_i - thr_ff) : (thr_ff - meas_i);
        stable = (gap > `STAB_BAND);
        out_lvl = detect ^ inv_ff;
        // Larger reading is the target, whichever came first
        hi = (meas_i > ref1_ff) ? meas_i : ref1_ff;
        lo = (meas_i > ref1_ff) ? ref1_ff : meas_i;
        diff = hi - lo;
        // Polarity follows whichever button opened the sequence
        first_btn = first_off_ff ? off_press : on_press;
        second_btn = first_off_ff ? on_press : off_press;
    end

    // ****************************************
    // Gesture and teach sequencer
    // ****************************************
    always @* begin
        nxt_state = state_ff;
        nxt_hold_cnt = hold_cnt_ff;
        nxt_teach_cnt = teach_cnt_ff;
        nxt_show_cnt = show_cnt_ff;
        nxt_first_off = first_off_ff;
        nxt_ref1 = ref1_ff;
        nxt_thr = thr_ff;
        nxt_inv = inv_ff;
        nxt_lock = lock_ff;
        // Hold counter saturates rather than wrapping into a false gesture
        if (tick && hold_cnt_ff != 14'h3FFF) begin
            nxt_hold_cnt = hold_cnt_ff + 14'h0001;
        end
        if (tick && (state_ff == ST_WAIT2 || state_ff == ST_HOLD2 ||
                     (state_ff == ST_HOLD1 && hold_cnt_ff > HOLD_TEACH_T))) begin
            nxt_teach_cnt = teach_cnt_ff + 20'h00001;
        end
        if (tick) begin
            nxt_show_cnt = show_cnt_ff + 12'h001;
        end
        case (state_ff)
            ST_IDLE: begin
                nxt_hold_cnt = 14'h0000;
                nxt_teach_cnt = 20'h00000;
                if (on_press && off_press) begin
                    nxt_state = ST_BOTH;
                end else if (!lock_ff && (on_press || off_press)) begin
                    nxt_first_off = off_press;
                    nxt_state = ST_HOLD1;
                end
            end
            ST_HOLD1: begin
                // A second press before release is read as the lock gesture
                if (second_btn) begin
                    nxt_hold_cnt = 14'h0000;
                    nxt_state = ST_BOTH;
                end else if (!first_btn) begin
                    if (hold_cnt_ff > HOLD_TEACH_T) begin
                        nxt_ref1 = meas_i;
                        nxt_state = ST_WAIT2;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_WAIT2: begin
                if (second_btn && !first_btn) begin
                    nxt_state = ST_HOLD2;
                end
            end
            ST_HOLD2: begin
                if (!second_btn) begin
                    nxt_show_cnt = 12'h000;
                    if (hi < `EMPTY_LVL) begin
                        nxt_thr = `MAX_RANGE_THR;
                        nxt_inv = first_off_ff;
                        nxt_state = ST_IDLE;
                    end else if (diff < `MIN_DIFF) begin
                        nxt_state = ST_FAIL;
                    end else begin
                        nxt_thr = lo + {1'b0, diff[`MEAS_W-1:1]};
                        nxt_inv = first_off_ff;
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_FAIL: begin
                if (show_cnt_ff >= FAIL_SHOW_T) begin
                    nxt_state = ST_REARM;
                end
            end
            ST_BOTH: begin
                nxt_show_cnt = 12'h000;
                if (!(on_press && off_press)) begin
                    nxt_state = ST_REARM;
                end else if (hold_cnt_ff >= HOLD_LOCK_T) begin
                    nxt_lock = ~lock_ff;
                    nxt_state = ST_ACK;
                end
            end
            ST_ACK: begin
                if (show_cnt_ff >= ACK_T) begin
                    nxt_state = ST_REARM;
                end
            end
            ST_REARM: begin
                // A button still held must not open a new gesture
                if (!on_press && !off_press) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // Timeout ends any open sequence; stored settings stay untouched
        if ((state_ff == ST_WAIT2 || state_ff == ST_HOLD2 || state_ff == ST_HOLD1) &&
            teach_cnt_ff > TEACH_MAX_T) begin
            nxt_show_cnt = 12'h000;
            nxt_thr = thr_ff;
            nxt_inv = inv_ff;
            nxt_state = ST_FAIL;
        end
    end

    // ****************************************
    // Flash generator
    // ****************************************
    always @* begin
        flashing = (state_ff == ST_WAIT2 || state_ff == ST_HOLD2 ||
                    (state_ff == ST_HOLD1 && hold_cnt_ff > HOLD_TEACH_T));
        half_t = (state_ff == ST_FAIL) ? FAIL_HALF_T : TEACH_HALF_T;
        nxt_flash = flash_ff;
        nxt_flash_cnt = flash_cnt_ff;
        // Restarting high makes arming visible at once
        if (!flashing && state_ff != ST_FAIL) begin
            nxt_flash = 1'b1;
            nxt_flash_cnt = 8'h00;
        end else if (tick) begin
            if (flash_cnt_ff >= half_t - 8'h01) begin
                nxt_flash_cnt = 8'h00;
                nxt_flash = ~flash_ff;
            end else begin
                nxt_flash_cnt = flash_cnt_ff + 8'h01;
            end
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= ST_IDLE;
            hold_cnt_ff <= 14'h0000;
            teach_cnt_ff <= 20'h00000;
            show_cnt_ff <= 12'h000;
            flash_cnt_ff <= 8'h00;
            flash_ff <= 1'b1;
            first_off_ff <= 1'b0;
            ref1_ff <= {`MEAS_W{1'b0}};
            thr_ff <= `THR_RST;
            inv_ff <= 1'b0;
            lock_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hold_cnt_ff <= nxt_hold_cnt;
            teach_cnt_ff <= nxt_teach_cnt;
            show_cnt_ff <= nxt_show_cnt;
            flash_cnt_ff <= nxt_flash_cnt;
            flash_ff <= nxt_flash;
            first_off_ff <= nxt_first_off;
            ref1_ff <= nxt_ref1;
            thr_ff <= nxt_thr;
            inv_ff <= nxt_inv;
            lock_ff <= nxt_lock;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            green_led_o <= 1'b0;
            yellow_led_o <= 1'b0;
            switch_out_o <= 1'b0;
            lock_o <= 1'b0;
            teach_busy_o <= 1'b0;
        end else begin
            // Registered so pins never glitch on decode
            green_led_o <= supply_ok && stable;
            switch_out_o <= out_lvl;
            lock_o <= lock_ff;
            teach_busy_o <= flashing;
            if (state_ff == ST_FAIL || flashing) begin
                yellow_led_o <= flash_ff;
            end else if (state_ff == ST_ACK) begin
                yellow_led_o <= ~out_lvl;
            end else begin
                yellow_led_o <= out_lvl;
            end
        end
    end

endmodule // teach_ctrl
`default_nettype wire

/* teach_ctrl_chk.sv */
// Port-level assertions for the teach controller
`timescale 1ns/10ps
`default_nettype none
module teach_chk #(
    parameter [15:0] TICK_DIV = 16'h9C40
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Pins and measurement
    input wire logic on_btn_n_i,
    input wire logic off_btn_n_i,
    input wire logic supply_ok_i,
    input wire logic [9:0] meas_i,
    // Indicators and output
    input wire logic green_led_o,
    input wire logic yellow_led_o,
    input wire logic switch_out_o,
    input wire logic lock_o,
    input wire logic teach_busy_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_GREEN_SUPPLY: assert property (!supply_ok_i [*6] |-> !green_led_o)
        else $error("green lit without supply");
    // Busy guard keeps the threshold update after a teach out of the window
    AST_SWITCH_STEADY: assert property ($stable(meas_i) && !teach_busy_o && !$past(teach_busy_o)
        && !$past(teach_busy_o, 2) && !$past(teach_busy_o, 3) && $past(resetn_i, 3)
        |=> $stable(switch_out_o))
        else $error("switch output moved with steady measurement");
    AST_LOCK_CAUSE: assert property ($changed(lock_o) |-> !$past(on_btn_n_i, 8) && !$past(off_btn_n_i, 8))
        else $error("lock toggled without both buttons");
    AST_LOCK_ACK: assert property ($changed(lock_o) |-> ##[0:2] (yellow_led_o != switch_out_o))
        else $error("lock toggle not acknowledged");
    AST_LOCKED_NO_TEACH: assert property (lock_o && $past(lock_o) |-> !$rose(teach_busy_o))
        else $error("teach armed while locked");
    AST_BUSY_CAUSE: assert property ($rose(teach_busy_o) |-> !$past(on_btn_n_i, 4) ^ !$past(off_btn_n_i, 4))
        else $error("teach armed without one button held");
    AST_BUSY_FLASH: assert property ($rose(teach_busy_o) |-> ##[0:2] yellow_led_o)
        else $error("teach flash did not start high");
    AST_BUSY_END: assert property ($fell(teach_busy_o) |-> $past(on_btn_n_i, 2) && $past(off_btn_n_i, 2))
        else $error("teach ended with a button held");
endmodule // teach_chk
`default_nettype wire

/* teach_map.vh */
// Constant map for the pushbutton teach-in and indication logic
`ifndef TEACH_MAP_VH
`define TEACH_MAP_VH

// ****************************************
// Clock and time base
// ****************************************
// Clocks per 1 ms tick at the 25 ns clock
`define TICK_CYCLES 16'h9C40

// ****************************************
// Gesture and teach timing, in ms ticks
// ****************************************
// Sized to the counters that compare against them
// 2 s teach hold
`define HOLD_TEACH_MS 14'h07D0
// 10 s lock hold
`define HOLD_LOCK_MS 14'h2710
// 15 min teach limit
`define TEACH_MAX_MS 20'hDBBA0
// 8 Hz fail flash, half period rounded down to whole ms
`define FAIL_HALF_MS 8'h3E
`define TEACH_HALF_MS 8'hFA
`define FAIL_SHOW_MS 12'hBB8
`define ACK_MS 12'h1F4

// ****************************************
// Measurement levels
// ****************************************
`define MEAS_W 10
`define THR_RST 10'h200
`define STAB_BAND 10'h020
`define MIN_DIFF 10'h040
`define EMPTY_LVL 10'h030
`define MAX_RANGE_THR 10'h018

`endif

/* testbench.sv */
// Self-checking bench for the teach controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int TD = 4;
    localparam int HOLD = 2010 * TD;
    logic core_clk_i;
    logic resetn_i;
    logic supply_ok_i;
    logic [9:0] meas_i;
    wire logic on_n;
    wire logic off_n;
    wire logic green;
    wire logic yellow;
    wire logic sw_out;
    wire logic lock;
    wire logic busy;
    int n_mismatch;
    int checks_done;

    operator_model i_op (.core_clk_i(core_clk_i), .on_btn_n_o(on_n), .off_btn_n_o(off_n));
    teach_ctrl #(.TICK_DIV(16'h0004)) i_dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .on_btn_n_i(on_n), .off_btn_n_i(off_n),
        .supply_ok_i(supply_ok_i), .meas_i(meas_i), .green_led_o(green), .yellow_led_o(yellow),
        .switch_out_o(sw_out), .lock_o(lock), .teach_busy_o(busy));

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic stop_test();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_int(input string what, input int exp, input int got);
        checks_done++;
        if (got != exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic probe(input logic [9:0] v, input logic sw);
        meas_i = v;
        wait_cyc(4);
        chk("switch_out", sw, sw_out);
        chk("yellow follows switch", sw, yellow);
    endtask
    task automatic gprobe(input logic [9:0] v, input logic g);
        meas_i = v;
        wait_cyc(4);
        chk("green", g, green);
    endtask
    task automatic teach(input logic on_first, input logic [9:0] m1, input logic [9:0] m2);
        meas_i = m1;
        i_op.push(on_first, ~on_first);
        wait_cyc(HOLD);
        chk("teach armed", 1'b1, busy);
        i_op.release_all();
        wait_cyc(10);
        meas_i = m2;
        i_op.push(~on_first, on_first);
        wait_cyc(20);
        i_op.release_all();
        wait_cyc(10);
        chk("teach ended", 1'b0, busy);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_basic();
        probe(10'h300, 1'b1);
        probe(10'h100, 1'b0);
        gprobe(10'h221, 1'b1);
        gprobe(10'h220, 1'b0);
        gprobe(10'h1E0, 1'b0);
        gprobe(10'h1DF, 1'b1);
        supply_ok_i = 1'b0;
        wait_cyc(8);
        chk("green without supply", 1'b0, green);
        supply_ok_i = 1'b1;
        wait_cyc(8);
    endtask
    task automatic t_normal();
        teach(1'b1, 10'h300, 10'h080);
        probe(10'h1C0, 1'b1);
        probe(10'h1BF, 1'b0);
    endtask
    task automatic t_fail();
        int n;
        logic y;
        teach(1'b1, 10'h200, 10'h220);
        // Align to one flash edge, then time a full half period
        y = yellow;
        n = 0;
        while (yellow === y && n < 600) begin
            wait_cyc(1);
            n++;
        end
        y = yellow;
        n = 0;
        while (yellow === y && n < 600) begin
            wait_cyc(1);
            n++;
        end
        chk_int("fail flash half period", 62 * TD, n);
        wait_cyc(3000 * TD);
        probe(10'h1C0, 1'b1);
        probe(10'h1BF, 1'b0);
    endtask
    task automatic t_inverted();
        teach(1'b0, 10'h080, 10'h300);
        probe(10'h300, 1'b0);
        probe(10'h080, 1'b1);
        gprobe(10'h1D0, 1'b0);
        gprobe(10'h300, 1'b1);
    endtask
    task automatic t_max();
        teach(1'b1, 10'h010, 10'h020);
        probe(10'h018, 1'b1);
        probe(10'h017, 1'b0);
    endtask
    task automatic t_lock();
        meas_i = 10'h300;
        i_op.push(1'b1, 1'b1);
        wait_cyc(10000 * TD + 20);
        chk("lock", 1'b1, lock);
        chk("ack inverts yellow", 1'b0, yellow);
        wait_cyc(500 * TD);
        chk("ack restored", 1'b1, yellow);
        i_op.release_all();
        wait_cyc(10);
        i_op.push(1'b1, 1'b0);
        wait_cyc(HOLD);
        chk("locked teach refused", 1'b0, busy);
        i_op.release_all();
        wait_cyc(10);
        chk("locked switch kept", 1'b1, sw_out);
    endtask

    initial begin
        n_mismatch = 0;
        checks_done = 0;
        resetn_i = 1'b0;
        supply_ok_i = 1'b1;
        meas_i = 10'h100;
        wait_cyc(8);
        resetn_i = 1'b1;
        wait_cyc(TD + 4);
        t_basic();
        t_normal();
        t_fail();
        t_inverted();
        t_max();
        t_lock();
        stop_test();
    end
    // Whole run is near 95k cycles; anything beyond this is a hang
    initial begin
        repeat (110000) @(posedge core_clk_i);
        n_mismatch++;
        stop_test();
    end
endmodule // testbench

bind teach_ctrl teach_chk #(.TICK_DIV(TICK_DIV)) i_chk (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .on_btn_n_i(on_btn_n_i), .off_btn_n_i(off_btn_n_i),
    .supply_ok_i(supply_ok_i), .meas_i(meas_i), .green_led_o(green_led_o), .yellow_led_o(yellow_led_o),
    .switch_out_o(switch_out_o), .lock_o(lock_o), .teach_busy_o(teach_busy_o));
`default_nettype wire
